// file: design/abx_executor.sv
`timescale 1ns/1ps
`default_nettype none
module abx_executor
  import abx_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ABX_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ABX_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  logic [ABX_ADDR_W-1:0] awaddr;
  logic [ABX_ADDR_W-1:0] next_awaddr;
  logic [31:0]           wdata;
  logic [31:0]           next_wdata;
  logic [3:0]            wstrb;
  logic [3:0]            next_wstrb;
  logic                  next_awready;
  logic                  next_wready;
  logic                  next_bvalid;
  logic [1:0]            next_bresp;
  logic                  next_arready;
  logic                  next_rvalid;
  logic [31:0]           next_rdata;
  logic [1:0]            next_rresp;
  logic                  commit;
  logic [13:0]           instr;
  logic [13:0]           next_instr;
  logic [7:0]            acc;
  logic [7:0]            next_acc;
  abx_flags_s            flags;
  abx_flags_s            next_flags;
  logic                  skip;
  logic                  next_skip;
  logic [31:0]           cycles;
  logic [31:0]           next_cycles;
  logic [7:0]            data_file [128];
  logic                  mem_we;
  logic [6:0]            mem_addr;
  logic [7:0]            mem_data;
  logic                  exec;
  logic [13:0]           instr_word;
  abx_dec_s              dec;
  logic [7:0]            file_rd;
  logic [7:0]            opnd;
  logic [8:0]            sum9;
  logic [4:0]            sum5;
  logic [7:0]            andv;
  function automatic logic is_mapped(input logic [ABX_ADDR_W-1:0] a);
    return (a == ABX_INSTR_OFS) || (a == ABX_ACC_OFS) || (a == ABX_STATUS_OFS) ||
           (a == ABX_CYCLES_OFS) ||
           (((a & ABX_FILE_MASK) == ABX_FILE_BASE) && (a[1:0] == 2'h0));
  endfunction
  function automatic logic [31:0] read_mux(input logic [ABX_ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == ABX_INSTR_OFS) begin
      v[13:0] = instr;
    end else if (a == ABX_ACC_OFS) begin
      v[7:0] = acc;
    end else if (a == ABX_STATUS_OFS) begin
      v[2:0]          = flags;
      v[ABX_SKIP_BIT] = skip;
    end else if (a == ABX_CYCLES_OFS) begin
      v = cycles;
    end else if (is_mapped(a)) begin
      v[7:0] = data_file[a[8:2]];
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: address and data taken in either order, response after both
  assign commit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_comb begin
    next_awaddr  = awaddr;
    next_wdata   = wdata;
    next_wstrb   = wstrb;
    next_awready = s_axi_awready;
    next_wready  = s_axi_wready;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awaddr  = s_axi_awaddr;
      next_awready = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wdata  = s_axi_wdata;
      next_wstrb  = s_axi_wstrb;
      next_wready = 1'b0;
    end
    if (commit) begin
      next_bvalid = 1'b1;
      next_bresp  = is_mapped(awaddr) ? ABX_RESP_OKAY : ABX_RESP_DECERR;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = read_mux(s_axi_araddr);
      next_rresp   = is_mapped(s_axi_araddr) ? ABX_RESP_OKAY : ABX_RESP_DECERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr        <= '0;
      wdata         <= 32'h0000_0000;
      wstrb         <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ABX_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ABX_RESP_OKAY;
    end else begin
      awaddr        <= next_awaddr;
      wdata         <= next_wdata;
      wstrb         <= next_wstrb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath: one committed write to the instruction register that strobes byte 0 or 1 is one cycle
  assign instr_word = {wstrb[1] ? wdata[13:8] : instr[13:8],
                       wstrb[0] ? wdata[7:0]  : instr[7:0]};
  assign exec       = commit && (awaddr == ABX_INSTR_OFS) && (wstrb[1:0] != 2'h0);
  assign dec        = abx_decode(instr_word);
  assign file_rd    = data_file[dec.file_addr];
  assign opnd       = (dec.op == ABX_ADD_IMMEDIATE_OP || dec.op == ABX_AND_IMMEDIATE_OP) ?
                      dec.lit : file_rd;
  assign sum9       = {1'b0, acc} + {1'b0, opnd};
  assign sum5       = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
  assign andv       = acc & opnd;
  always_comb begin
    next_instr  = instr;
    next_acc    = acc;
    next_flags  = flags;
    next_skip   = skip;
    next_cycles = cycles;
    mem_we      = 1'b0;
    mem_addr    = dec.file_addr;
    mem_data    = file_rd;
    if (exec) begin
      next_instr  = instr_word;
      next_cycles = cycles + 32'h0000_0001;
      if (skip) begin
        next_skip = 1'b0;
      end else begin
        case (dec.op)
          ABX_ADD_IMMEDIATE_OP, ABX_ADD_REGISTER_OP: begin
            next_flags.carry          = sum9[8];
            next_flags.half_byte_flag = sum5[4];
            next_flags.zero           = (sum9[7:0] == 8'h00);
            if (dec.op == ABX_ADD_REGISTER_OP && dec.dest) begin
              mem_we   = 1'b1;
              mem_data = sum9[7:0];
            end else begin
              next_acc = sum9[7:0];
            end
          end
          ABX_AND_IMMEDIATE_OP, ABX_AND_REGISTER_OP: begin
            next_flags.zero = (andv == 8'h00);
            if (dec.op == ABX_AND_REGISTER_OP && dec.dest) begin
              mem_we   = 1'b1;
              mem_data = andv;
            end else begin
              next_acc = andv;
            end
          end
          ABX_BIT_CLEAR_OP: begin
            mem_we                = 1'b1;
            mem_data[dec.bitpos]  = 1'b0;
          end
          ABX_BIT_SET_OP: begin
            mem_we                = 1'b1;
            mem_data[dec.bitpos]  = 1'b1;
          end
          ABX_TEST_SKIP_IF_ZERO_OP: begin
            next_skip = !file_rd[dec.bitpos];
          end
          default: ;
        endcase
      end
    end else if (commit && wstrb[0]) begin
      if (awaddr == ABX_ACC_OFS) begin
        next_acc = wdata[7:0];
      end else if (awaddr == ABX_STATUS_OFS) begin
        next_flags = abx_flags_s'(wdata[2:0]);
      end else if (is_mapped(awaddr) && awaddr != ABX_CYCLES_OFS &&
                   awaddr != ABX_INSTR_OFS) begin
        mem_we   = 1'b1;
        mem_addr = awaddr[8:2];
        mem_data = wdata[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr  <= ABX_INSTR_RST;
      acc    <= ABX_ACC_RST;
      flags  <= ABX_FLAGS_RST;
      skip   <= 1'b0;
      cycles <= ABX_CYCLES_RST;
    end else begin
      instr  <= next_instr;
      acc    <= next_acc;
      flags  <= next_flags;
      skip   <= next_skip;
      cycles <= next_cycles;
    end
  end

  // Data registers hold no reset value
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      data_file[mem_addr] <= mem_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic live;
  assign live = exec && !skip;
  sequence skip_armed_s;
    exec && !skip && dec.op == ABX_TEST_SKIP_IF_ZERO_OP && !file_rd[dec.bitpos];
  endsequence
  sequence nop_slot_s;
    skip && exec;
  endsequence
  add_imm_result_a: assert property (
    live && dec.op == ABX_ADD_IMMEDIATE_OP |=>
      acc == 8'($past(acc) + $past(dec.lit)) && flags.zero == (acc == 8'h00))
    else $error("immediate add result wrong");
  add_reg_carry_a: assert property (
    live && dec.op == ABX_ADD_REGISTER_OP |=>
      flags.carry == ({1'b0, $past(acc)} + {1'b0, $past(file_rd)} > 9'h0FF))
    else $error("register add carry wrong");
  and_imm_flags_a: assert property (
    live && dec.op == ABX_AND_IMMEDIATE_OP |=>
      acc == ($past(acc) & $past(dec.lit)) && flags.carry == $past(flags.carry) &&
      flags.half_byte_flag == $past(flags.half_byte_flag))
    else $error("immediate AND wrong");
  and_reg_flags_a: assert property (
    live && dec.op == ABX_AND_REGISTER_OP |=>
      $stable(flags.carry) && $stable(flags.half_byte_flag) &&
      flags.zero == (($past(acc) & $past(file_rd)) == 8'h00))
    else $error("register AND flags wrong");
  dest_select_a: assert property (
    live && (dec.op == ABX_ADD_REGISTER_OP || dec.op == ABX_AND_REGISTER_OP) && dec.dest
      |=> $stable(acc))
    else $error("file destination touched accumulator");
  bit_clear_a: assert property (
    live && dec.op == ABX_BIT_CLEAR_OP |=>
      data_file[$past(dec.file_addr)][$past(dec.bitpos)] == 1'b0 && $stable(flags))
    else $error("bit clear failed");
  bit_set_a: assert property (
    live && dec.op == ABX_BIT_SET_OP |=>
      data_file[$past(dec.file_addr)][$past(dec.bitpos)] == 1'b1 && $stable(flags))
    else $error("bit set failed");
  test_one_a: assert property (
    live && dec.op == ABX_TEST_SKIP_IF_ZERO_OP && file_rd[dec.bitpos] |=>
      !skip && $stable(flags) && $stable(acc))
    else $error("test with one bit misbehaved");
  skip_arm_a: assert property (
    skip_armed_s |=> skip && $stable(acc) && $stable(flags))
    else $error("failed test did not arm the skip");
  skip_hold_a: assert property (
    skip && !exec |=> skip)
    else $error("pending skip lost before the next slot");
  skip_nop_a: assert property (
    nop_slot_s |=> !skip && $stable(acc) && $stable(flags) &&
      data_file[$past(dec.file_addr)] == $past(file_rd))
    else $error("skipped slot was not a no-op");
  decode_other_a: assert property (
    live && dec.op == ABX_NO_OP |=> $stable(acc) && $stable(flags) && !skip)
    else $error("unknown opcode changed state");
  half_flag_a: assert property (
    live && (dec.op == ABX_ADD_IMMEDIATE_OP || dec.op == ABX_ADD_REGISTER_OP) |=>
      flags.half_byte_flag == ($past(acc[3:0]) + $past(opnd[3:0]) > 5'h0F))
    else $error("half byte flag wrong");
endmodule
`default_nettype wire

// file: design/abx_pkg.sv
`default_nettype none
package abx_pkg;

  localparam int          ABX_ADDR_W       = 12;
  localparam int          ABX_INSTR_W      = 14;

  // Register byte offsets
  localparam logic [11:0] ABX_INSTR_OFS    = 12'h000;
  localparam logic [11:0] ABX_ACC_OFS      = 12'h004;
  localparam logic [11:0] ABX_STATUS_OFS   = 12'h008;
  localparam logic [11:0] ABX_CYCLES_OFS   = 12'h00C;
  localparam logic [11:0] ABX_FILE_BASE    = 12'h200;
  localparam logic [11:0] ABX_FILE_MASK    = 12'hE00;

  // Values after reset
  localparam logic [13:0] ABX_INSTR_RST    = 14'h0000;
  localparam logic [7:0]  ABX_ACC_RST      = 8'h00;
  localparam logic [2:0]  ABX_FLAGS_RST    = 3'h0;
  localparam logic [31:0] ABX_CYCLES_RST   = 32'h0000_0000;

  // Status register bit positions
  localparam int          ABX_SKIP_BIT     = 3;

  // Instruction field positions
  localparam int          ABX_DEST_BIT     = 7;
  localparam int          ABX_BITPOS_LSB   = 7;

  // Opcode prefixes
  localparam logic [5:0]  ABX_ADD_REG_PFX  = 6'h07;
  localparam logic [5:0]  ABX_AND_REG_PFX  = 6'h05;
  localparam logic [3:0]  ABX_BIT_CLR_PFX  = 4'h4;
  localparam logic [3:0]  ABX_BIT_SET_PFX  = 4'h5;
  localparam logic [3:0]  ABX_TEST_PFX     = 4'h6;
  localparam logic [4:0]  ABX_ADD_IMM_PFX  = 5'h1F;
  localparam logic [5:0]  ABX_AND_IMM_PFX  = 6'h39;

  localparam logic [1:0]  ABX_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  ABX_RESP_DECERR  = 2'h3;

  typedef enum logic [2:0] {
    ABX_NO_OP,
    ABX_ADD_IMMEDIATE_OP,
    ABX_ADD_REGISTER_OP,
    ABX_AND_IMMEDIATE_OP,
    ABX_AND_REGISTER_OP,
    ABX_BIT_CLEAR_OP,
    ABX_BIT_SET_OP,
    ABX_TEST_SKIP_IF_ZERO_OP
  } abx_op_e;

  typedef struct packed {
    logic zero;
    logic half_byte_flag;
    logic carry;
  } abx_flags_s;

  typedef struct packed {
    abx_op_e    op;
    logic       dest;
    logic [2:0] bitpos;
    logic [6:0] file_addr;
    logic [7:0] lit;
  } abx_dec_s;

  function automatic abx_dec_s abx_decode(input logic [13:0] ins);
    abx_dec_s d;
    d.dest      = ins[ABX_DEST_BIT];
    d.bitpos    = ins[ABX_BITPOS_LSB +: 3];
    d.file_addr = ins[6:0];
    d.lit       = ins[7:0];
    if (ins[13:9] == ABX_ADD_IMM_PFX) begin
      d.op = ABX_ADD_IMMEDIATE_OP;
    end else if (ins[13:8] == ABX_AND_IMM_PFX) begin
      d.op = ABX_AND_IMMEDIATE_OP;
    end else if (ins[13:8] == ABX_ADD_REG_PFX) begin
      d.op = ABX_ADD_REGISTER_OP;
    end else if (ins[13:8] == ABX_AND_REG_PFX) begin
      d.op = ABX_AND_REGISTER_OP;
    end else if (ins[13:10] == ABX_BIT_CLR_PFX) begin
      d.op = ABX_BIT_CLEAR_OP;
    end else if (ins[13:10] == ABX_BIT_SET_PFX) begin
      d.op = ABX_BIT_SET_OP;
    end else if (ins[13:10] == ABX_TEST_PFX) begin
      d.op = ABX_TEST_SKIP_IF_ZERO_OP;
    end else begin
      d.op = ABX_NO_OP;
    end
    return d;
  endfunction

endpackage
`default_nettype wire

// file: test/abx_executor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module abx_executor_tb_top
  import abx_pkg::*;
();
  typedef struct packed {
    logic [7:0]  acc0;
    logic [7:0]  f0;
    logic [2:0]  st0;
    logic [13:0] ins;
    logic [7:0]  acc_x;
    logic [7:0]  f_x;
    logic [2:0]  st_x;
  } abx_row_s;

  logic                  aclk;
  logic                  aresetn;
  logic [ABX_ADDR_W-1:0] s_axi_awaddr;
  logic                  s_axi_awvalid;
  logic                  s_axi_awready;
  logic [31:0]           s_axi_wdata;
  logic [3:0]            s_axi_wstrb;
  logic                  s_axi_wvalid;
  logic                  s_axi_wready;
  logic [1:0]            s_axi_bresp;
  logic                  s_axi_bvalid;
  logic                  s_axi_bready;
  logic [ABX_ADDR_W-1:0] s_axi_araddr;
  logic                  s_axi_arvalid;
  logic                  s_axi_arready;
  logic [31:0]           s_axi_rdata;
  logic [1:0]            s_axi_rresp;
  logic                  s_axi_rvalid;
  logic                  s_axi_rready;
  int                    n_fail;
  int                    comparisons;
  logic [31:0]           rd;
  logic [1:0]            rsp;
  logic [31:0]           cyc;

  // Acc, file value, flags before; instruction; acc, file value, flags after
  abx_row_s rows [15] = '{
    '{8'h0F, 8'h55, 3'h0, 14'h3E01, 8'h10, 8'h55, 3'h2},
    '{8'hFF, 8'h00, 3'h0, 14'h3F01, 8'h00, 8'h00, 3'h7},
    '{8'h12, 8'h00, 3'h7, 14'h3E34, 8'h46, 8'h00, 3'h0},
    '{8'hF0, 8'h00, 3'h3, 14'h390F, 8'h00, 8'h00, 3'h7},
    '{8'hFF, 8'h00, 3'h4, 14'h39A5, 8'hA5, 8'h00, 3'h0},
    '{8'h80, 8'h80, 3'h0, 14'h077F, 8'h00, 8'h80, 3'h5},
    '{8'h09, 8'h08, 3'h0, 14'h0780, 8'h09, 8'h11, 3'h2},
    '{8'h3C, 8'h0F, 3'h7, 14'h0505, 8'h0C, 8'h0F, 3'h3},
    '{8'h0F, 8'hF0, 3'h0, 14'h0586, 8'h0F, 8'h00, 3'h4},
    '{8'h00, 8'hFF, 3'h5, 14'h138A, 8'h00, 8'h7F, 3'h5},
    '{8'h00, 8'h01, 3'h2, 14'h1040, 8'h00, 8'h00, 3'h2},
    '{8'hAA, 8'h00, 3'h0, 14'h1401, 8'hAA, 8'h01, 3'h0},
    '{8'h00, 8'h00, 3'h7, 14'h17FE, 8'h00, 8'h80, 3'h7},
    '{8'h33, 8'h08, 3'h6, 14'h1982, 8'h33, 8'h08, 3'h6},
    '{8'h5A, 8'hC3, 3'h1, 14'h2ABC, 8'h5A, 8'hC3, 3'h1}
  };

  abx_executor i_abx_executor (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awprot  (3'h0),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arprot  (3'h0),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [11:0] faddr(input logic [6:0] f);
    return ABX_FILE_BASE + {3'h0, f, 2'h0};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    r = 2'h2;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'h3;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (aw_ok && w_ok && s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (n == 50) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (ar_ok && s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (!ar_ok && s_axi_arready) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    if (n == 50) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  task automatic expect_reg(input string what, input logic [11:0] a, input logic [31:0] exp);
    rd_reg(a, rd, rsp);
    check(what, rd, exp);
    check("read resp", {30'h0, rsp}, {30'h0, ABX_RESP_OKAY});
  endtask

  task automatic exec(input logic [13:0] ins);
    wr(ABX_INSTR_OFS, {18'h0, ins}, rsp);
    cyc = cyc + 32'h1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0;
    comparisons = 0;
    cyc = 32'h0;
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    expect_reg("acc reset", ABX_ACC_OFS, {24'h0, ABX_ACC_RST});
    expect_reg("status reset", ABX_STATUS_OFS, 32'h0);
    expect_reg("instr reset", ABX_INSTR_OFS, {18'h0, ABX_INSTR_RST});
    expect_reg("cycles reset", ABX_CYCLES_OFS, ABX_CYCLES_RST);

    foreach (rows[i]) begin
      wr(ABX_ACC_OFS, {24'h0, rows[i].acc0}, rsp);
      wr(faddr(rows[i].ins[6:0]), {24'h0, rows[i].f0}, rsp);
      wr(ABX_STATUS_OFS, {29'h0, rows[i].st0}, rsp);
      exec(rows[i].ins);
      expect_reg("acc", ABX_ACC_OFS, {24'h0, rows[i].acc_x});
      expect_reg("file", faddr(rows[i].ins[6:0]), {24'h0, rows[i].f_x});
      expect_reg("status", ABX_STATUS_OFS, {29'h0, rows[i].st_x});
      expect_reg("instr", ABX_INSTR_OFS, {18'h0, rows[i].ins});
    end

    // Zero bit seen: the following slot is thrown away, first an add, then a test that arms nothing
    wr(faddr(7'h11), 32'h0000_00F7, rsp);
    wr(ABX_ACC_OFS, 32'h0000_0001, rsp);
    wr(ABX_STATUS_OFS, 32'h0000_0005, rsp);
    exec(14'h1991);
    expect_reg("skip set", ABX_STATUS_OFS, 32'h0000_000D);
    exec(14'h3E02);
    expect_reg("acc skipped", ABX_ACC_OFS, 32'h0000_0001);
    expect_reg("skip cleared", ABX_STATUS_OFS, 32'h0000_0005);
    exec(14'h1991);
    exec(14'h1991);
    expect_reg("second test discarded", ABX_STATUS_OFS, 32'h0000_0005);
    exec(14'h3E02);
    expect_reg("acc after skip", ABX_ACC_OFS, 32'h0000_0003);
    expect_reg("cycles", ABX_CYCLES_OFS, cyc);

    // Refused accesses, and a cycles write answered OKAY but ignored
    rd_reg(12'h010, rd, rsp);
    check("unmapped resp", {30'h0, rsp}, {30'h0, ABX_RESP_DECERR});
    check("unmapped data", rd, 32'h0);
    wr(12'h005, 32'h0000_0077, rsp);
    check("unaligned resp", {30'h0, rsp}, {30'h0, ABX_RESP_DECERR});
    wr(ABX_CYCLES_OFS, 32'h0000_0000, rsp);
    check("cycles write resp", {30'h0, rsp}, {30'h0, ABX_RESP_OKAY});
    expect_reg("cycles kept", ABX_CYCLES_OFS, cyc);
    expect_reg("acc untouched", ABX_ACC_OFS, 32'h0000_0003);

    // Reset again in mid-run
    wr(ABX_ACC_OFS, 32'h0000_00C3, rsp);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    expect_reg("acc rerun", ABX_ACC_OFS, 32'h0);
    expect_reg("cycles rerun", ABX_CYCLES_OFS, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
